// ---- pkg/iow_pkg.sv ----
// Constants for the first I/O wake-up configuration register block.
// Assumes a 16-bit serial frame port with the device as slave, mode 0.
package iow_pkg;
  localparam int          FRAME_BITS    = 16;
  localparam logic        FLAG_WRITE    = 1'h1;
  localparam logic [5:0]  REG_ADDR      = 6'h04;
  localparam int          POS_WRITE     = 15;
  localparam int          POS_ADDR_HI   = 14;
  localparam int          POS_ADDR_LO   = 9;
  localparam int          POS_PARITY    = 8;
  localparam int          POS_SEL_PIN0  = 6;
  localparam int          POS_SEL_PIN1  = 4;
  localparam int          POS_SEL_PIN2  = 2;
  localparam int          POS_INH_PIN1  = 1;
  localparam int          POS_INH_PIN0  = 0;
  localparam int          POS_FLAG_IO   = 3;
  localparam logic [7:0]  RESET_VALUE   = 8'h00;
  localparam logic [7:0]  READ_DATA     = 8'h00;
  localparam logic [3:0]  BIT_COUNT_MAX = 4'hF;
  localparam logic [1:0]  SEL_NONE      = 2'h0;
  localparam logic [1:0]  SEL_RISE      = 2'h1;
  localparam logic [1:0]  SEL_FALL      = 2'h2;
  localparam logic [1:0]  SEL_ANY       = 2'h3;
endpackage : iow_pkg

// ---- core/iow_edge_sel.sv ----
// Edge-selective wake detector for one configurable I/O pin.
// Assumes the pin level is already synchronised to CLOCK.
`timescale 1ns/1ps
`default_nettype none
module iow_edge_sel
  import iow_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Pin and selection
  input  wire logic       level,
  input  wire logic [1:0] sel,
  // Event out
  output logic            event_pulse
);
  logic last_level;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_level <= 1'b0;
    end else begin
      last_level <= level;
    end
  end

  always_comb begin
    unique case (sel)
      SEL_NONE: event_pulse = 1'b0;
      SEL_RISE: event_pulse = level & ~last_level;
      SEL_FALL: event_pulse = ~level & last_level;
      SEL_ANY:  event_pulse = level ^ last_level;
    endcase
  end
endmodule : iow_edge_sel
`default_nettype wire

// ---- core/iow_config_reg.sv ----
// Serial-frame register holding wake edge selection for I/O pins 0 to 2 and
// interrupt inhibit for pins 0 and 1, with wake and interrupt event outputs.
// Assumes a serial master driving SCLK, CSB, MOSI; all pins synchronised here.
`timescale 1ns/1ps
`default_nettype none
module iow_config_reg
  import iow_pkg::*;
(
  // Clock and power-on reset
  input  wire logic       CLOCK,
  input  wire logic       RESET,
  // Serial port pins
  input  wire logic       SCLK,
  input  wire logic       CS_N,
  input  wire logic       MOSI,
  output logic            MISO,
  output logic            MISO_OE,
  // Global flag sources other than the I/O flag
  input  wire logic [7:0] GLOBAL_FLAGS,
  // Configurable I/O pin levels, pins 0 to 2
  input  wire logic [2:0] IO_PIN,
  // Outputs to wake-up and interrupt logic
  output logic [2:0]      WAKE_EVENT,
  output logic [2:0]      INT_REQUEST,
  output logic            IO_FLAG,
  output logic [7:0]      CONFIG_VALUE,
  output logic            WRITE_REJECTED
);
  logic [2:0]  sclk_sync;
  logic [1:0]  cs_sync;
  logic [1:0]  mosi_sync;
  logic [2:0]  pin_meta;
  logic [2:0]  pin_sync;
  logic [7:0]  flags_meta;
  logic [7:0]  flags_sync;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        frame_active;
  logic        cs_last;
  logic        frame_end;
  logic [15:0] rx_shift;
  logic [15:0] tx_shift;
  logic [4:0]  bit_count;
  logic [7:0]  config_reg;
  logic [2:0]  edge_event;
  logic [2:0]  int_allowed;
  logic        next_io_flag;
  logic [15:0] next_reply;
  logic        frame_ok;
  logic        addr_match;
  logic        parity_ok;

  // Two flops on every pin; sclk gets a third stage for edge detection
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      sclk_sync  <= 3'h0;
      cs_sync    <= 2'h3;
      mosi_sync  <= 2'h0;
      pin_meta   <= 3'h0;
      pin_sync   <= 3'h0;
      flags_meta <= 8'h00;
      flags_sync <= 8'h00;
    end else begin
      sclk_sync  <= {sclk_sync[1:0], SCLK};
      cs_sync    <= {cs_sync[0], CS_N};
      mosi_sync  <= {mosi_sync[0], MOSI};
      pin_meta   <= IO_PIN;
      pin_sync   <= pin_meta;
      flags_meta <= GLOBAL_FLAGS;
      flags_sync <= flags_meta;
    end
  end

  assign sclk_rise    = sclk_sync[1] & ~sclk_sync[2];
  assign sclk_fall    = ~sclk_sync[1] & sclk_sync[2];
  assign frame_active = ~cs_sync[1];
  assign frame_end    = cs_sync[1] & ~cs_last;

  // Per-pin edge detectors
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_pin
      logic [1:0] sel;
      assign sel = config_reg[POS_SEL_PIN0 - 2*g +: 2];
      iow_edge_sel u_edge (
        .clk         (CLOCK),
        .rst         (RESET),
        .level       (pin_sync[g]),
        .sel         (sel),
        .event_pulse (edge_event[g])
      );
    end
  endgenerate

  // Pin 2 inhibit lives in another register; never inhibited here
  assign int_allowed = {1'b1,
                        ~config_reg[POS_INH_PIN1],
                        ~config_reg[POS_INH_PIN0]};

  // Reply frame: global flags with local I/O flag merged, then register
  always_comb begin
    next_io_flag = flags_sync[POS_FLAG_IO] | IO_FLAG;
    next_reply   = {flags_sync[7:4], next_io_flag, flags_sync[2:0], config_reg};
  end

  // Frame decode
  assign addr_match = rx_shift[POS_ADDR_HI:POS_ADDR_LO] == REG_ADDR;
  assign parity_ok  = ^rx_shift;
  assign frame_ok   = (bit_count == 5'h10) && addr_match;

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      cs_last   <= 1'b1;
      bit_count <= 5'h00;
      rx_shift  <= 16'h0000;
    end else begin
      cs_last <= cs_sync[1];
      if (!frame_active) begin
        bit_count <= 5'h00;
      end else if (sclk_rise) begin
        rx_shift <= {rx_shift[14:0], mosi_sync[1]};
        if (bit_count != 5'h1F) begin
          bit_count <= bit_count + 5'h01;
        end
      end
    end
  end

  // Shift out on falling edges; MSB presented as soon as the frame opens
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      tx_shift <= 16'h0000;
      MISO     <= 1'b0;
      MISO_OE  <= 1'b0;
    end else begin
      MISO_OE <= frame_active;
      if (!frame_active) begin
        tx_shift <= next_reply;
        MISO     <= next_reply[FRAME_BITS-1];
      end else if (sclk_fall) begin
        tx_shift <= {tx_shift[14:0], 1'b0};
        MISO     <= tx_shift[14];
      end
    end
  end

  // Register: cleared only by the power-on reset input
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      config_reg     <= RESET_VALUE;
      WRITE_REJECTED <= 1'b0;
    end else begin
      WRITE_REJECTED <= 1'b0;
      if (frame_end && frame_ok && rx_shift[POS_WRITE] == FLAG_WRITE) begin
        if (parity_ok) begin
          config_reg <= rx_shift[7:0];
        end else begin
          WRITE_REJECTED <= 1'b1;
        end
      end
    end
  end

  // Event outputs; inhibited pins still pulse WAKE_EVENT but neither INT_REQUEST nor the I/O flag
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      WAKE_EVENT   <= 3'h0;
      INT_REQUEST  <= 3'h0;
      IO_FLAG      <= 1'b0;
      CONFIG_VALUE <= RESET_VALUE;
    end else begin
      WAKE_EVENT   <= edge_event;
      INT_REQUEST  <= edge_event & int_allowed;
      CONFIG_VALUE <= config_reg;
      // Set wins over the read-clear at frame end
      if (|(edge_event & int_allowed)) begin
        IO_FLAG <= 1'b1;
      end else if (frame_end && frame_ok) begin
        IO_FLAG <= 1'b0;
      end
    end
  end
endmodule : iow_config_reg
`default_nettype wire

// ---- verification/iow_asserts.sv ----
// Checker on the config register ports.
// Bound to iow_config_reg; one clock, async power-on reset.
`timescale 1ns/1ps
`default_nettype none
module iow_asserts
  import iow_pkg::*;
(
  // Clock, reset, frame
  input wire logic       CLOCK,
  input wire logic       RESET,
  input wire logic       CS_N,
  input wire logic       MISO_OE,
  // Events and register
  input wire logic [2:0] WAKE_EVENT,
  input wire logic [2:0] INT_REQUEST,
  input wire logic       IO_FLAG,
  input wire logic [7:0] CONFIG_VALUE,
  input wire logic       WRITE_REJECTED
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);
  int_pass_a: assert property (WAKE_EVENT[0] && !CONFIG_VALUE[0] |-> ##[0:1] INT_REQUEST[0])
    else $error("pin0 int lost");
  int_mask_a: assert property (CONFIG_VALUE[1] |-> !INT_REQUEST[1])
    else $error("pin1 int leaked");
  pin2_int_a: assert property (WAKE_EVENT[2] |-> ##[0:1] INT_REQUEST[2])
    else $error("pin2 int lost");
  io_flag_a: assert property (WAKE_EVENT[0] && !CONFIG_VALUE[0] |-> ##[0:2] IO_FLAG)
    else $error("io flag not set");
  oe_on_a: assert property ($fell(CS_N) |-> ##[1:6] MISO_OE)
    else $error("reply not driven");
  oe_off_a: assert property ($rose(CS_N) |-> ##[1:6] !MISO_OE)
    else $error("reply not released");
  reset_val_a: assert property ($fell(RESET) |-> CONFIG_VALUE == RESET_VALUE)
    else $error("reset value wrong");
  rej_hold_a: assert property (WRITE_REJECTED |-> ##1 $stable(CONFIG_VALUE) [*3])
    else $error("refused write landed");
endmodule : iow_asserts
bind iow_config_reg iow_asserts u_chk (.CLOCK, .RESET, .CS_N, .MISO_OE, .WAKE_EVENT,
  .INT_REQUEST, .IO_FLAG, .CONFIG_VALUE, .WRITE_REJECTED);
`default_nettype wire

// ---- verification/iow_host.sv ----
// Host master model: sends frames, gathers replies.
// Mode 0, SCLK idle low; bench calls xfer.
`timescale 1ns/1ps
`default_nettype none
module iow_host (
  // Clock
  input wire logic CLOCK,
  // Serial pins
  output logic     SCLK,
  output logic     CS_N,
  output logic     MOSI,
  input wire logic MISO
);
  initial {SCLK, CS_N, MOSI} = 3'h2;
  // Half period of 5 cycles, above the 4 minimum
  task automatic xfer(input logic [15:0] f, output logic [15:0] r);
    @(negedge CLOCK) CS_N = 1'h0;
    for (int i = 15; i >= 0; i--) begin
      MOSI = f[i];
      repeat (5) @(negedge CLOCK);
      SCLK = 1'h1;
      r[i] = MISO;
      repeat (5) @(negedge CLOCK);
      SCLK = 1'h0;
    end
    repeat (5) @(negedge CLOCK);
    CS_N = 1'h1;
    // Released line must not keep its value
    MOSI = ~MOSI;
    repeat (8) @(negedge CLOCK);
  endtask : xfer
endmodule : iow_host
`default_nettype wire

// ---- verification/tb_top.sv ----
// Bench: host model frames plus pin toggles.
// Inputs change on falling CLOCK edges.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import iow_pkg::*;
  ;
  logic        CLOCK, RESET, SCLK, CS_N, MOSI, MISO, MISO_OE, IO_FLAG, WRITE_REJECTED;
  logic [7:0]  GLOBAL_FLAGS, CONFIG_VALUE;
  logic [2:0]  IO_PIN, WAKE_EVENT, INT_REQUEST;
  logic [15:0] rep;
  logic [3:0]  nw [3], ni [3], nrej;
  int          n_fail = 0, compares = 0;
  iow_config_reg DUT (.CLOCK, .RESET, .SCLK, .CS_N, .MOSI, .MISO, .MISO_OE, .GLOBAL_FLAGS,
    .IO_PIN, .WAKE_EVENT, .INT_REQUEST, .IO_FLAG, .CONFIG_VALUE, .WRITE_REJECTED);
  iow_host u_host (.CLOCK, .SCLK, .CS_N, .MOSI, .MISO);
  initial begin
    CLOCK = 1'h0;
    forever #20 CLOCK = ~CLOCK;
  end
  // Counted, since events last one cycle
  always @(posedge CLOCK) begin
    for (int i = 0; i < 3; i++) begin
      nw[i] <= nw[i] + 4'(WAKE_EVENT[i]);
      ni[i] <= ni[i] + 4'(INT_REQUEST[i]);
    end
    nrej <= nrej + 4'(WRITE_REJECTED);
  end
  task automatic clr;
    nw = '{3{4'h0}};
    ni = '{3{4'h0}};
    nrej = 4'h0;
  endtask : clr
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  function automatic logic [15:0] wf(input logic [7:0] d);
    wf = {FLAG_WRITE, REG_ADDR, 1'h0, d};
    wf[POS_PARITY] = ~^wf;
  endfunction : wf
  task automatic xf(input logic w, input logic [7:0] d);
    u_host.xfer(w ? wf(d) : {1'h0, REG_ADDR, 9'h000}, rep);
  endtask : xf
  task automatic t_reset;
    xf(1'h0, 8'h00);
    chk("after reset", rep, {GLOBAL_FLAGS, RESET_VALUE});
  endtask : t_reset
  task automatic t_write;
    logic [7:0] d;
    for (int k = 0; k < 4; k++) begin
      d = {k[1:0], ~k[1:0], k[1:0], k[0], ~k[0]};
      xf(1'h1, d);
      xf(1'h0, 8'h00);
      chk("readback", rep, {GLOBAL_FLAGS, d});
    end
  endtask : t_write
  // Bad parity, then a foreign address
  task automatic t_reject;
    clr;
    u_host.xfer(wf(8'h5A) ^ 16'h0100, rep);
    u_host.xfer(wf(8'h5A) ^ 16'h0600, rep);
    xf(1'h0, 8'h00);
    chk("refused", {rep[7:0], nrej, 4'h0}, 16'hCE10);
  endtask : t_reject
  task automatic t_edges;
    xf(1'h1, 8'h6E);
    clr;
    @(negedge CLOCK) IO_PIN = 3'h7;
    repeat (8) @(negedge CLOCK);
    chk("io flag", {15'h0, IO_FLAG}, 16'h0001);
    IO_PIN = 3'h0;
    repeat (8) @(negedge CLOCK);
    chk("wakes", {nw[0], nw[1], nw[2], 4'h0}, 16'h1120);
    chk("ints", {ni[0], ni[1], ni[2], 4'h0}, 16'h1020);
    xf(1'h0, 8'h00);
    chk("flag bit", {15'h0, rep[11]}, 16'h0001);
    xf(1'h1, 8'h22);
    clr;
    @(negedge CLOCK) IO_PIN = 3'h7;
    repeat (8) @(negedge CLOCK);
    IO_PIN = 3'h0;
    repeat (8) @(negedge CLOCK);
    chk("masked", {IO_FLAG, 3'h0, nw[1], ni[1], nw[0]}, 16'h0100);
  endtask : t_edges
  task automatic t_por;
    xf(1'h1, 8'hFF);
    @(negedge CLOCK) RESET = 1'h1;
    repeat (2) @(negedge CLOCK);
    RESET = 1'h0;
    repeat (3) @(negedge CLOCK);
    xf(1'h0, 8'h00);
    chk("por", rep, {GLOBAL_FLAGS, RESET_VALUE});
  endtask : t_por
  task automatic test_done;
    if (n_fail == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done
  initial begin
    {RESET, IO_PIN, GLOBAL_FLAGS} = {1'h1, 3'h0, 8'hA5};
    clr;
    repeat (2) @(negedge CLOCK);
    RESET = 1'h0;
    repeat (3) @(negedge CLOCK);
    t_reset;
    t_write;
    t_reject;
    t_edges;
    t_por;
    test_done;
  end
  initial begin
    #1_000_000;
    n_fail++;
    test_done;
  end
endmodule : tb_top
`default_nettype wire
